// ===== hw/lsf_status_flags.sv
// Diagnostic status register bank with latched fault output.
// Assumes an I2C slave front end presents one-cycle read and write strobes with an address.
`timescale 1ns/100ps
module lsf_status_flags
(
  input wire logic clk,
  input wire logic rst,
  input lsf_pkg::lsf_cond_t cond,
  input lsf_pkg::lsf_req_t req,
  output logic [7:0] rdata,
  output logic rvalid,
  output logic fault_n
);
  import lsf_pkg::*;

  logic tone_q;
  logic linreg_q;
  logic hot_q;
  logic tsd_flag_q;
  logic ocp_flag_q;
  logic cable_q;
  logic vout_q;
  logic [7:0] status_word;
  logic [7:0] rdata_d;
  logic [7:0] rdata_q;
  logic rvalid_q;
  logic status_rd;
  logic tsd_q;
  logic ocp_q;
  logic tsd_rise;
  logic ocp_rise;
  logic fault_event;

  // Rising edge of a level against its previous sample
  function automatic logic lsf_rise(input logic now_level, input logic prev_level);
    lsf_rise = now_level && !prev_level;
  endfunction

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      tone_q <= LSF_STATUS_RESET[LSF_BIT_TONE];
    end
    else
    begin
      tone_q <= cond.tone_detect_in_range;
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      linreg_q <= LSF_STATUS_RESET[LSF_BIT_LINREG];
    end
    else
    begin
      linreg_q <= cond.linear_reg_active;
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      hot_q <= LSF_STATUS_RESET[LSF_BIT_HOT];
    end
    else
    begin
      hot_q <= cond.die_hot_warning;
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      tsd_flag_q <= LSF_STATUS_RESET[LSF_BIT_TSD];
    end
    else
    begin
      tsd_flag_q <= cond.thermal_shutdown_flag;
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      ocp_flag_q <= LSF_STATUS_RESET[LSF_BIT_OCP];
    end
    else
    begin
      ocp_flag_q <= cond.overcurrent_flag;
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      cable_q <= LSF_STATUS_RESET[LSF_BIT_CABLE];
    end
    else
    begin
      cable_q <= cond.cable_good;
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      vout_q <= LSF_STATUS_RESET[LSF_BIT_VOUT];
    end
    else
    begin
      vout_q <= cond.output_voltage_in_range;
    end
  end

  // Bit 7 held zero, writes unused
  always_comb
  begin
    status_word = 8'h00;
    status_word[LSF_BIT_TONE] = tone_q;
    status_word[LSF_BIT_LINREG] = linreg_q;
    status_word[LSF_BIT_HOT] = hot_q;
    status_word[LSF_BIT_TSD] = tsd_flag_q;
    status_word[LSF_BIT_OCP] = ocp_flag_q;
    status_word[LSF_BIT_CABLE] = cable_q;
    status_word[LSF_BIT_VOUT] = vout_q;
  end

  assign status_rd = req.rd && (req.addr == LSF_STATUS_ADDR);

  // Other addresses return zero
  always_comb
  begin
    if (status_rd)
    begin
      rdata_d = status_word;
    end
    else
    begin
      rdata_d = 8'h00;
    end
  end

  // Read data holds until the next read
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      rdata_q <= 8'h00;
    end
    else if (req.rd)
    begin
      rdata_q <= rdata_d;
    end
  end

  // Read answered one cycle later
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      rvalid_q <= 1'b0;
    end
    else
    begin
      rvalid_q <= req.rd;
    end
  end

  // Previous shutdown level
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      tsd_q <= 1'b0;
    end
    else
    begin
      tsd_q <= cond.thermal_shutdown_flag;
    end
  end

  // Previous overcurrent level
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      ocp_q <= 1'b0;
    end
    else
    begin
      ocp_q <= cond.overcurrent_flag;
    end
  end

  assign tsd_rise = lsf_rise(cond.thermal_shutdown_flag, tsd_q);
  assign ocp_rise = lsf_rise(cond.overcurrent_flag, ocp_q);
  assign fault_event = tsd_rise || ocp_rise;

  lsf_fault_latch u_latch
  (
    .clk(clk),
    .rst(rst),
    .fault_event(fault_event),
    .release_rd(status_rd),
    .fault_n(fault_n)
  );

  assign rdata = rdata_q;
  assign rvalid = rvalid_q;
endmodule

// ===== hw/lsf_pkg.sv
// Constants and carrier types for the LNB diagnostic status register bank.
// Assumes a register read port driven by an I2C front end elsewhere in the device.
package lsf_pkg;
  localparam logic [7:0] LSF_STATUS_ADDR = 8'h02;
  localparam logic [7:0] LSF_STATUS_RESET = 8'h29;
  localparam int LSF_BIT_TONE = 6;
  localparam int LSF_BIT_LINREG = 5;
  localparam int LSF_BIT_HOT = 4;
  localparam int LSF_BIT_TSD = 3;
  localparam int LSF_BIT_OCP = 2;
  localparam int LSF_BIT_CABLE = 1;
  localparam int LSF_BIT_VOUT = 0;

  typedef struct packed {
    logic tone_detect_in_range;
    logic linear_reg_active;
    logic die_hot_warning;
    logic thermal_shutdown_flag;
    logic overcurrent_flag;
    logic cable_good;
    logic output_voltage_in_range;
  } lsf_cond_t;

  typedef struct packed {
    logic rd;
    logic wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } lsf_req_t;
endpackage

// ===== hw/lsf_fault_latch.sv
// Latched active-low fault indication.
// Assumes events and read pulse are synchronous to clk.
`timescale 1ns/100ps
module lsf_fault_latch
(
  input wire logic clk,
  input wire logic rst,
  input wire logic fault_event,
  input wire logic release_rd,
  output logic fault_n
);
  import lsf_pkg::*;

  logic latched_q;

  // Release on read; a new event wins
  always_ff @(posedge clk)
  begin
    if (rst)
      latched_q <= 1'b0;
    else if (fault_event)
      latched_q <= 1'b1;
    else if (release_rd)
      latched_q <= 1'b0;
  end

  assign fault_n = ~latched_q;
endmodule

// ===== test/lsf_status_flags_properties.sv
// Port checker for the status bank, bound into lsf_status_flags.
`timescale 1ns/100ps
module lsf_status_flags_properties (input wire logic clk,
  input wire logic rst,
  input lsf_pkg::lsf_cond_t cond,
  input lsf_pkg::lsf_req_t req,
  input wire logic [7:0] rdata,
  input wire logic rvalid,
  input wire logic fault_n);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  wire rs = req.rd && req.addr == 8'h02;
  property p_rv; req.rd |=> rvalid; endproperty
  a_rv: assert property (p_rv) else $error("no rvalid");
  property p_rd; rs && !$past(rst) |=> rdata[6:0] == $past(cond, 2); endproperty
  a_rd: assert property (p_rd) else $error("stale");
  property p_b7; rvalid |-> !rdata[7]; endproperty
  a_b7: assert property (p_b7) else $error("bit 7");
  property p_um; req.rd && !rs |=> rdata == 8'h00; endproperty
  a_um: assert property (p_um) else $error("unmapped");
  property p_ts; $rose(cond.thermal_shutdown_flag) |=> !fault_n; endproperty
  a_ts: assert property (p_ts) else $error("no fault");
  property p_oc; $rose(cond.overcurrent_flag) |=> !fault_n; endproperty
  a_oc: assert property (p_oc) else $error("no fault");
  property p_hd; !fault_n && !rs |=> !fault_n; endproperty
  a_hd: assert property (p_hd) else $error("early release");
  property p_rl; rs && $stable(cond) |=> fault_n; endproperty
  a_rl: assert property (p_rl) else $error("no release");
  c_rd: cover property (rs ##1 rvalid);
  c_ts: cover property ($rose(cond.thermal_shutdown_flag) ##1 !fault_n);
  c_oc: cover property ($rose(cond.overcurrent_flag) ##1 !fault_n);
  c_rl: cover property (!fault_n ##1 rs ##1 fault_n);
endmodule
bind lsf_status_flags lsf_status_flags_properties i_chk (.clk, .rst, .cond, .req, .rdata, .rvalid, .fault_n);

// ===== test/lsf_host_model.sv
// Host model: passes each request on a cycle later, scrambles idle lines.
`timescale 1ns/100ps
module lsf_host_model (input wire logic clk,
  input lsf_pkg::lsf_req_t cmd,
  output lsf_pkg::lsf_req_t req);
  // Forward rd/wr requests; on idle cycles invert addr and wdata
  always_ff @(posedge clk)
  begin
    if (cmd.rd || cmd.wr)
      req <= cmd;
    else
      req <= '{1'b0, 1'b0, ~req.addr, ~req.wdata};
  end
endmodule

// ===== test/lsf_status_flags_tb_top.sv
// Bench: flag walk, ignored writes, unmapped reads, fault release.
`timescale 1ns/100ps
module lsf_status_flags_tb_top;
  logic clk = 0, rst = 1, rvalid, fault_n;
  logic [7:0] rdata;
  lsf_pkg::lsf_cond_t cond = '0;
  lsf_pkg::lsf_req_t cmd = '0, req;
  int mismatches = 0, n_checks = 0;
  always #5 clk = ~clk;
  lsf_host_model i_host (.clk, .cmd, .req);
  lsf_status_flags i_dut (.clk, .rst, .cond, .req, .rdata, .rvalid, .fault_n);
  task chk(logic [9:0] s, e);
    n_checks++;
    mismatches += int'(s !== e);
    if (s !== e) $display("wrong value rvalid,fault_n,rdata exp %h seen %h", e, s);
  endtask
  task op(logic w, logic [7:0] a, logic [8:0] e);
    @(posedge clk) cmd <= '{!w, w, a, 8'hff};
    @(posedge clk) cmd <= '0;
    @(posedge clk) #1 chk({rvalid, fault_n, rdata}, {!w, e});
  endtask
  task final_report;
    $display("checks %0d wrong %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  initial
  begin
    #5000 mismatches++;
    final_report;
  end
  initial
  begin
    repeat (7) @(posedge clk);
    cmd <= '{1'b1, 1'b0, 8'h02, 8'hff};
    @(posedge clk) rst <= 0;
    cmd <= '0;
    @(posedge clk) #1 chk({rvalid, fault_n, rdata}, {2'b11, lsf_pkg::LSF_STATUS_RESET});
    $display("test reset done");
    for (int i = 0; i < 7; i++)
    begin
      @(posedge clk) cond <= 7'(1 << i);
      op(1, 8'h02, {1'(i < 2 || i > 3), (i == 0) ? lsf_pkg::LSF_STATUS_RESET : 8'(1 << i) >> 1});
      op(0, 8'h05, {1'(i < 2 || i > 3), 8'h00});
      op(0, 8'h02, {1'b1, 8'(1 << i)});
      $display("test %0d done", i);
    end
    final_report;
  end
endmodule
